// [dv/mt16_timer_asserts.sv]
// Port checks of the match timer
`timescale 1ns/1ps
module mt16_timer_asserts (
	input logic        i_sys_clk,
	input logic        i_reset,
	input logic        i_wr,
	input logic        i_rd,
	input logic        o_square_out,
	input logic        o_match_irq,
	input logic [7:0]  i_addr,
	input logic [31:0] i_wdata,
	input logic [31:0] o_rdata
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	wire wc = i_wr && i_addr == 8'h08;
	wire [8:0] rq = {i_rd, i_addr};
	a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
		else $error("stray rdata");
	a_cfg_unused: assert property ($past(rq) == 9'h100 |-> o_rdata[31:2] == 30'h0)
		else $error("cfg bits");
	a_force_reads: assert property ($past(rq) == 9'h108 |-> o_rdata[5:4] == 2'h3)
		else $error("force read");
	a_force_set: assert property (wc && i_wdata[5:4] == 2'h1 |=> o_square_out)
		else $error("force set");
	a_force_clr: assert property (wc && i_wdata[5:4] == 2'h2 |=> !o_square_out)
		else $error("force clear");
	a_force_inv: assert property (wc && i_wdata[5:4] == 2'h0
		|=> o_square_out != $past(o_square_out)) else $error("force invert");
	a_irq_sticky: assert property (o_match_irq && !i_wr |=> o_match_irq)
		else $error("irq lost");
	a_reset_quiet: assert property (disable iff (1'b0) i_reset
		|=> !o_match_irq && !o_square_out) else $error("reset state");
	c_irq: cover property ($rose(o_match_irq));
	c_tog: cover property ($changed(o_square_out));
	c_ctl: cover property (wc);
endmodule // mt16_timer_asserts
bind mt16_timer mt16_timer_asserts i_chk (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
	.i_wr(i_wr), .i_rd(i_rd), .o_square_out(o_square_out), .o_match_irq(o_match_irq),
	.i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata));

// [dv/mt16_timer_tb.sv]
// Bench for the match timer
`timescale 1ns/1ps
module mt16_timer_tb;
	logic i_sys_clk = 0, i_reset = 1, i_wr = 0, i_rd = 0, i_idle = 0, i_debug_halt = 0, s;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0, o_rdata;
	logic o_square_out, o_match_irq;
	int failures = 0, n_tests = 0, n;
	mt16_timer i_mt16_timer (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_idle(i_idle),
		.i_debug_halt(i_debug_halt), .o_square_out(o_square_out), .o_match_irq(o_match_irq));
	initial forever #50 i_sys_clk = ~i_sys_clk;
	task chk(input logic [31:0] g, e);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("ERROR %0t mismatch got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
		#1;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1 chk(o_rdata, e);
	endtask
	task t_regs;
		rd(8'h08, 32'h30);
		wr(8'h00, 32'hFFFFFFFF);
		rd(8'h00, 32'h3);
		wr(8'h00, 32'h0);
		for (n = 0; n < 3; n++)
			wr(8'h08, ((n + 1) % 3) << 4);
		chk(o_square_out, 1);
	endtask
	task t_match;
		wr(8'h0C, 32'h5);
		wr(8'h18, 32'h1);
		wr(8'h08, 32'hB0);
		wr(8'h04, 32'h1);
		repeat (2) begin
			s = o_square_out;
			n = 0;
			while (o_square_out === s && n < 40) begin
				@(posedge i_sys_clk);
				#1 n++;
			end
		end
		chk(n, 6);
		chk(o_match_irq, 1);
		wr(8'h04, 32'h0);
		wr(8'h10, 32'h3);
		rd(8'h10, 32'h3);
		wr(8'h14, 32'h1);
		chk(o_match_irq, 0);
	endtask
	task t_stall;
		for (n = 0; n < 4; n++) begin
			i_idle <= !n[0];
			i_debug_halt <= n[0];
			wr(8'h00, (n == 1) ? 32'h2 : (n == 2) ? 32'h1 : 32'h0);
			wr(8'h10, 32'h0);
			wr(8'h04, 32'h1);
			repeat (9) @(posedge i_sys_clk);
			wr(8'h04, 32'h0);
			rd(8'h10, (n < 2) ? 32'h0 : 32'h5);
		end
	endtask
	task t_presc;
		wr(8'h0C, 32'h1);
		wr(8'h10, 32'h0);
		wr(8'h08, 32'hB1);
		wr(8'h04, 32'h1);
		repeat (2) begin
			s = o_square_out;
			n = 0;
			while (o_square_out === s && n < 40) begin
				@(posedge i_sys_clk);
				#1 n++;
			end
		end
		chk(n, 16);
		wr(8'h04, 32'h0);
		rd(8'h08, 32'hB1);
		rd(8'h18, 32'h1);
		rd(8'h1C, 32'h0);
		rd(8'h20, 32'h0);
	endtask
	task t_reset;
		wr(8'h04, 32'h1);
		@(posedge i_sys_clk);
		i_reset <= 1'b1;
		repeat (2) @(posedge i_sys_clk);
		i_reset <= 1'b0;
		@(posedge i_sys_clk);
		#1 chk(o_match_irq, 0);
		chk(o_square_out, 0);
		rd(8'h04, 32'h0);
		rd(8'h10, 32'h0);
	endtask
	task complete_run;
		$display("checks %0d errors %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge i_sys_clk);
		i_reset <= 1'b0;
		t_regs;
		t_match;
		t_stall;
		t_presc;
		t_reset;
		complete_run;
	end
	initial begin
		#100000;
		failures++;
		complete_run;
	end
endmodule // mt16_timer_tb

// [verilog/mt16_map.vh]
// Register map, field positions and reset values of the match timer
`ifndef MT16_MAP_VH
`define MT16_MAP_VH
`define MT16_ADDR_W        8
`define MT16_OFF_LPCFG     8'h00
`define MT16_OFF_RUN       8'h04
`define MT16_OFF_CTRL      8'h08
`define MT16_OFF_CMP       8'h0C
`define MT16_OFF_SNAP      8'h10
`define MT16_OFF_IRQ_STAT  8'h14
`define MT16_OFF_IRQ_MASK  8'h18
`define MT16_OFF_CHAN_ID   8'h1C
`define MT16_LP_IDLE_BIT   0
`define MT16_LP_HALT_BIT   1
`define MT16_RUN_BIT       0
`define MT16_CR_CLK_BIT    0
`define MT16_CR_FFC_LO     4
`define MT16_CR_FFC_HI     5
`define MT16_CR_MATCH_TOGGLE_ENABLE_BIT   7
`define MT16_CR_COUNTER_CLEAR_CTL_BIT   15
`define MT16_FFC_INVERT    2'h0
`define MT16_FFC_SET       2'h1
`define MT16_FFC_CLEAR     2'h2
`define MT16_FFC_NOP       2'h3
`define MT16_IRQ_MATCH_BIT 0
`define MT16_ZERO16        16'h0000
`define MT16_ZERO32        32'h0000_0000
`define MT16_PRESC_DIV     8
`endif

// [verilog/mt16_presc.v]
// Prescaler that makes a one-cycle enable pulse for the slow source clock
`timescale 1ns/1ps
`include "mt16_map.vh"
module mt16_presc #(
	parameter DIV = `MT16_PRESC_DIV
) (
	input  wire i_sys_clk,
	input  wire i_reset,
	input  wire i_run,
	output reg  o_tick
);
	localparam CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam [31:0]   LAST_FULL = DIV - 1;
	localparam [CW-1:0] LAST      = LAST_FULL[CW-1:0];
	reg [CW-1:0] count;
	always @(posedge i_sys_clk) begin
		if (i_reset || !i_run) begin
			count  <= {CW{1'b0}};
			o_tick <= 1'b0;
		end else if (count == LAST) begin
			count  <= {CW{1'b0}};
			o_tick <= 1'b1;
		end else begin
			count  <= count + 1'b1;
			o_tick <= 1'b0;
		end
	end
endmodule // mt16_presc

// [verilog/mt16_timer.v]
// One 16-bit match timer channel with register port and interrupt
// How it works
// - Eight word registers at offsets 0x00, 0x04, 0x08, 0x0C, 0x10, 0x14, 0x18, 0x1C.
// - Config bit 1 set stops counting during debug halt.
// - Config bit 0 clear stops counting in idle mode.
// - Match interrupt, square output, live count read; channel index readable.
// - Count up each source tick; equal to compare reloads zero.
// - Counter equal to compare raises the match interrupt.
// - Force field: 00 invert, 01 set, 10 clear, 11 none; reads 11.
// - Run clear stops and holds the count.
`timescale 1ns/1ps
`include "mt16_map.vh"
module mt16_timer #(
	parameter       CNT_W   = 16,
	parameter       DIV     = `MT16_PRESC_DIV,
	parameter [7:0] CHAN_ID = 8'h00
) (
	input  wire                    i_sys_clk,
	input  wire                    i_reset,
	input  wire [`MT16_ADDR_W-1:0] i_addr,
	input  wire [31:0]             i_wdata,
	input  wire                    i_wr,
	input  wire                    i_rd,
	output reg  [31:0]             o_rdata,
	input  wire                    i_idle,
	input  wire                    i_debug_halt,
	output reg                     o_square_out,
	output wire                    o_match_irq
);
	reg              idle_keep_running;
	reg              halt_stop;
	reg              run;
	reg              clk_sel;
	reg              match_toggle_enable;
	reg              counter_clear_ctl;
	reg  [CNT_W-1:0] compare_value;
	reg  [CNT_W-1:0] count;
	reg              irq_stat;
	reg              irq_mask;
	wire             presc_tick;
	wire             sel_lp;
	wire             sel_run;
	wire             sel_cr;
	wire             sel_cmp;
	wire             sel_snap;
	wire             sel_stat;
	wire             sel_mask;
	wire             gated;
	wire             tick;
	wire             match;
	wire [1:0]       ffc;

	assign sel_lp   = (i_addr == `MT16_OFF_LPCFG);
	assign sel_run  = (i_addr == `MT16_OFF_RUN);
	assign sel_cr   = (i_addr == `MT16_OFF_CTRL);
	assign sel_cmp  = (i_addr == `MT16_OFF_CMP);
	assign sel_snap = (i_addr == `MT16_OFF_SNAP);
	assign sel_stat = (i_addr == `MT16_OFF_IRQ_STAT);
	assign sel_mask = (i_addr == `MT16_OFF_IRQ_MASK);
	assign ffc      = i_wdata[`MT16_CR_FFC_HI:`MT16_CR_FFC_LO];

	// Automatic stop in idle or debug halt
	assign gated = run
		&& !(i_idle && !idle_keep_running)
		&& !(i_debug_halt && halt_stop);

	mt16_presc #(
		.DIV (DIV)
	) u_presc (
		.i_sys_clk (i_sys_clk),
		.i_reset   (i_reset),
		.i_run     (gated),
		.o_tick    (presc_tick)
	);

	// Source clock select
	assign tick  = gated && (clk_sel ? presc_tick : 1'b1);
	assign match = tick && (count == compare_value);

	// Registers written by software
	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			idle_keep_running   <= 1'b0;
			halt_stop           <= 1'b0;
			run                 <= 1'b0;
			clk_sel             <= 1'b0;
			match_toggle_enable <= 1'b0;
			counter_clear_ctl   <= 1'b0;
			compare_value       <= {CNT_W{1'b0}};
			irq_mask            <= 1'b0;
		end else if (i_wr) begin
			if (sel_lp) begin
				idle_keep_running <= i_wdata[`MT16_LP_IDLE_BIT];
				halt_stop         <= i_wdata[`MT16_LP_HALT_BIT];
			end
			if (sel_run)
				run <= i_wdata[`MT16_RUN_BIT];
			if (sel_cr) begin
				clk_sel             <= i_wdata[`MT16_CR_CLK_BIT];
				match_toggle_enable <= i_wdata[`MT16_CR_MATCH_TOGGLE_ENABLE_BIT];
				counter_clear_ctl   <= i_wdata[`MT16_CR_COUNTER_CLEAR_CTL_BIT];
			end
			if (sel_cmp)
				compare_value <= i_wdata[CNT_W-1:0];
			if (sel_mask)
				irq_mask <= i_wdata[`MT16_IRQ_MATCH_BIT];
		end
	end

	// Counter: snapshot write loads, match reloads zero, run clear holds
	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			count <= {CNT_W{1'b0}};
		end else if (i_wr && sel_snap) begin
			count <= i_wdata[CNT_W-1:0];
		end else if (match) begin
			count <= {CNT_W{1'b0}};
		end else if (tick) begin
			count <= count + 1'b1;
		end
	end

	// Square output: software force, else toggle on match
	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_square_out <= 1'b0;
		end else if (i_wr && sel_cr && ffc != `MT16_FFC_NOP) begin
			case (ffc)
				`MT16_FFC_INVERT: o_square_out <= ~o_square_out;
				`MT16_FFC_SET:    o_square_out <= 1'b1;
				`MT16_FFC_CLEAR:  o_square_out <= 1'b0;
				default:          o_square_out <= o_square_out;
			endcase
		end else if (match && match_toggle_enable) begin
			o_square_out <= ~o_square_out;
		end
	end

	// Sticky match status, write one to clear, set wins
	always @(posedge i_sys_clk) begin
		if (i_reset)
			irq_stat <= 1'b0;
		else if (match)
			irq_stat <= 1'b1;
		else if (i_wr && sel_stat && i_wdata[`MT16_IRQ_MATCH_BIT])
			irq_stat <= 1'b0;
	end

	assign o_match_irq = irq_stat & irq_mask;

	// Read data, one cycle after the strobe
	always @(posedge i_sys_clk) begin
		if (i_reset) begin
			o_rdata <= `MT16_ZERO32;
		end else if (i_rd) begin
			o_rdata <= `MT16_ZERO32;
			case (i_addr)
				`MT16_OFF_LPCFG: begin
					o_rdata[`MT16_LP_IDLE_BIT] <= idle_keep_running;
					o_rdata[`MT16_LP_HALT_BIT] <= halt_stop;
				end
				`MT16_OFF_RUN: o_rdata[`MT16_RUN_BIT] <= run;
				`MT16_OFF_CTRL: begin
					o_rdata[`MT16_CR_CLK_BIT]  <= clk_sel;
					o_rdata[`MT16_CR_FFC_HI:`MT16_CR_FFC_LO] <= `MT16_FFC_NOP;
					o_rdata[`MT16_CR_MATCH_TOGGLE_ENABLE_BIT] <= match_toggle_enable;
					o_rdata[`MT16_CR_COUNTER_CLEAR_CTL_BIT] <= counter_clear_ctl;
				end
				`MT16_OFF_CMP:      o_rdata[CNT_W-1:0] <= compare_value;
				`MT16_OFF_SNAP:     o_rdata[CNT_W-1:0] <= count;
				`MT16_OFF_IRQ_STAT: o_rdata[`MT16_IRQ_MATCH_BIT] <= irq_stat;
				`MT16_OFF_IRQ_MASK: o_rdata[`MT16_IRQ_MATCH_BIT] <= irq_mask;
				`MT16_OFF_CHAN_ID:  o_rdata[7:0] <= CHAN_ID;
				default:            o_rdata <= `MT16_ZERO32;
			endcase
		end else begin
			o_rdata <= `MT16_ZERO32;
		end
	end
endmodule // mt16_timer
